// ### shared/gpio_func_defines.svh
// register offsets, field positions, reset values, codes and timing counts
`ifndef GPIO_FUNC_DEFINES_SVH
`define GPIO_FUNC_DEFINES_SVH

// register offsets on the internal register port
`define STATUS_ADDR 8'h23
`define CONFIG_ADDR 8'h24

// reset values
`define STATUS_RESET 16'h0000
`define CONFIG_RESET 16'h0000

// status register fields
`define ST_PROTECT_BIT 8
`define ST_WIN_CH0_BIT 7
`define ST_WIN_CH1_BIT 4
`define ST_CMP_CH0_BIT 3
`define ST_CMP_CH1_BIT 0

// config register fields
`define CFG_FILTER_BIT 15
`define CFG_OUT_EN_BIT 13
`define CFG_OUT_SEL_HI 12
`define CFG_OUT_SEL_LO 9
`define CFG_MASK_HI 8
`define CFG_MASK_LO 5
`define CFG_FUNC_HI 4
`define CFG_FUNC_LO 1
`define CFG_IN_EN_BIT 0
`define CFG_WMASK 16'hBFFF

// channel mask bit per channel
`define MASK_CH1_BIT 0
`define MASK_CH0_BIT 3

// output select codes
`define OSEL_NV_BUSY 4'h1
`define OSEL_CH1_BUSY 4'h4
`define OSEL_CH0_BUSY 4'h7
`define OSEL_WIN_CH1 4'h8
`define OSEL_WIN_CH0 4'hB

// input function codes
`define IFN_FAULT_DUMP 4'h2
`define IFN_CURRENT_PD 4'h3
`define IFN_VOLTAGE_PD 4'h4
`define IFN_PROTECT 4'h5
`define IFN_CLEAR 4'h7
`define IFN_LOAD 4'h8
`define IFN_WAVE 4'h9
`define IFN_MARGIN 4'hA
`define IFN_RESET 4'hB
`define IFN_NV_PROTECT 4'hC
`define IFN_MAP_LOCK 4'hD

// glitch filter settle time, rounded up to whole cycles
`define CLK_PERIOD_NS 10
`define GLITCH_NS 100
`define GLITCH_CYCLES ((`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### shared/gpio_func_pkg.sv
// types shared by the pin function block
package gpio_func_pkg;
  typedef logic [3:0] func_code_t;
  typedef logic [15:0] reg_word_t;
  typedef enum logic [1:0] {filt_idle, filt_settle} filt_state_t;
endpackage

// ### src/pin_sync2.sv
// two-flop synchroniser for asynchronous levels
`timescale 1ns/10ps
module pin_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // first stage, read by the second stage only
  logic [WIDTH-1:0] meta;

  // both stages load a constant under reset
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      meta <= INIT;
      sync_out <= INIT;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ### src/pin_glitch_filter.sv
// stability filter: a new level passes only after it holds for a set time
`timescale 1ns/10ps
`include "gpio_func_defines.svh"
module pin_glitch_filter
  import gpio_func_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic level_in,
  output logic level_out
);
  localparam int SETTLE = `GLITCH_CYCLES;
  // settle counter
  logic [7:0] count;
  filt_state_t state;

  // a pulse shorter than the settle time never reaches the output
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= filt_idle;
      count <= 8'h00;
      level_out <= 1'b1;
    end else begin
      case (state)
        filt_idle: begin
          count <= 8'h00;
          if (level_in != level_out) begin
            state <= filt_settle;
          end
        end
        filt_settle: begin
          if (level_in == level_out) begin
            state <= filt_idle;
          end else if (count == 8'(SETTLE - 1)) begin
            level_out <= level_in;
            state <= filt_idle;
          end else begin
            count <= count + 8'h01;
          end
        end
        default: begin
          state <= filt_idle;
        end
      endcase
    end
  end
endmodule

// ### src/gpio_function_and_comparator_and_shutdown_status.sv
// multifunction pin and comparator/safe-shutdown status registers
// Operation
// - shutdown flag bit 8, cleared on read
// - window results bits 7,4, latch selectable
// - synchronised comparator results in bits 3,0
// - bit 15 inserts glitch filter on input
// - drive pin only while bit 13 set
// - bits 12-9 pick status bit driven out
// - bits 8-5 channel mask, bit0 ch1, bit3 ch0
// - global codes whole device, others masked channels
// - code 0010 falling edge starts fault dump
// - code 0011 current output down/up by edge
// - code 0100 voltage output down/up by edge
// - code 0101 falling edge starts safe shutdown
// - code 0111 clear held while pin low
// - code 1000 falling edge loads masked channels
// - code 1001 waveform stop fall, start rise
// - code 1010 margin low fall, high rise
// - code 1011 reset from fall to rise
// - code 1100 nonvolatile write allowed after fall
// - code 1101 register lock after rising edge
// - input functions act only while bit 0 set
// - compare hold clear wipes held window results
`timescale 1ns/10ps
`include "gpio_func_defines.svh"
module gpio_function_and_comparator_and_shutdown_status
  import gpio_func_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  // internal register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output reg_word_t reg_rdata,
  // general-purpose pin
  input wire logic gpio_in,
  output logic gpio_out,
  output logic gpio_oe,
  // comparator sources, asynchronous, index 0 is channel 0
  input wire logic [1:0] compare_raw,
  input wire logic [1:0] window_raw,
  input wire logic window_latch_enable,
  input wire logic [1:0] compare_hold_clear,
  // device status from the rest of the chip
  input wire logic protect_active,
  input wire logic nonvolatile_busy,
  input wire logic [1:0] channel_busy,
  input wire logic unlock_write,
  // actions, index 0 is channel 0
  output logic fault_dump_start,
  output logic protect_start,
  output logic clear_function_n,
  output logic [1:0] current_output_down,
  output logic [1:0] current_output_up,
  output logic [1:0] voltage_output_down,
  output logic [1:0] voltage_output_up,
  output logic [1:0] load_update,
  output logic [1:0] wave_stop,
  output logic [1:0] wave_start,
  output logic [1:0] margin_low,
  output logic [1:0] margin_high,
  output logic device_reset_req,
  output logic nonvolatile_write_allow,
  output logic register_lock
);

  // configuration register
  reg_word_t config_q;
  // sticky shutdown flag
  logic protect_flag;
  // window results as reported
  logic [1:0] window_compare_result;
  // synchronised comparator inputs
  logic [1:0] synced_compare_result;
  logic [1:0] window_sync;
  // pin path
  logic pin_sync;
  logic pin_filtered;
  logic pin_level;
  logic pin_prev;

  // config fields
  wire input_filter_enable = config_q[`CFG_FILTER_BIT];
  wire pin_output_enable = config_q[`CFG_OUT_EN_BIT];
  wire [3:0] pin_output_select = config_q[`CFG_OUT_SEL_HI:`CFG_OUT_SEL_LO];
  wire [3:0] pin_input_channel_mask = config_q[`CFG_MASK_HI:`CFG_MASK_LO];
  wire [3:0] pin_input_function = config_q[`CFG_FUNC_HI:`CFG_FUNC_LO];
  wire pin_input_enable = config_q[`CFG_IN_EN_BIT];

  // register decode
  wire sel_status = (reg_addr == `STATUS_ADDR);
  wire sel_config = (reg_addr == `CONFIG_ADDR);
  wire status_read = reg_rd && sel_status;
  // lock blocks config updates; unlock writes arrive on their own strobe
  wire config_write = reg_wr && sel_config && !register_lock;

  // comparator and window synchronisers
  pin_sync2 #(
    .WIDTH(2),
    .INIT(2'h0)
  ) u_cmp_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in(compare_raw),
    .sync_out(synced_compare_result)
  );

  pin_sync2 #(
    .WIDTH(2),
    .INIT(2'h0)
  ) u_win_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in(window_raw),
    .sync_out(window_sync)
  );

  // pin synchroniser, idle level high
  pin_sync2 #(
    .WIDTH(1),
    .INIT(1'b1)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in(gpio_in),
    .sync_out(pin_sync)
  );

  // filter runs on the synchronised level, never on the raw pin
  pin_glitch_filter u_filter (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .level_in(pin_sync),
    .level_out(pin_filtered)
  );

  // filter bypass trades robustness for fewer cycles of delay
  assign pin_level = input_filter_enable ? pin_filtered : pin_sync;

  // one-cycle edge marks and a low level, gated by input enable
  wire pin_fall = pin_input_enable && pin_prev && !pin_level;
  wire pin_rise = pin_input_enable && !pin_prev && pin_level;
  wire pin_low = pin_input_enable && !pin_level;

  // function decode
  wire fn_fault = (pin_input_function == `IFN_FAULT_DUMP);
  wire fn_cur = (pin_input_function == `IFN_CURRENT_PD);
  wire fn_volt = (pin_input_function == `IFN_VOLTAGE_PD);
  wire fn_prot = (pin_input_function == `IFN_PROTECT);
  wire fn_clear = (pin_input_function == `IFN_CLEAR);
  wire fn_load = (pin_input_function == `IFN_LOAD);
  wire fn_wave = (pin_input_function == `IFN_WAVE);
  wire fn_margin = (pin_input_function == `IFN_MARGIN);
  wire fn_reset = (pin_input_function == `IFN_RESET);
  wire fn_nvp = (pin_input_function == `IFN_NV_PROTECT);
  wire fn_lock = (pin_input_function == `IFN_MAP_LOCK);

  // channel enables from the mask; note the reversed bit order
  wire [1:0] chan_en = {pin_input_channel_mask[`MASK_CH1_BIT],
                        pin_input_channel_mask[`MASK_CH0_BIT]};

  // pin output selection, unused codes drive low
  logic next_gpio_out;
  always_comb begin
    case (pin_output_select)
      `OSEL_NV_BUSY: next_gpio_out = nonvolatile_busy;
      `OSEL_CH1_BUSY: next_gpio_out = channel_busy[1];
      `OSEL_CH0_BUSY: next_gpio_out = channel_busy[0];
      `OSEL_WIN_CH1: next_gpio_out = window_compare_result[1];
      `OSEL_WIN_CH0: next_gpio_out = window_compare_result[0];
      default: next_gpio_out = 1'b0;
    endcase
  end

  // status word as read back
  wire [15:0] status_word = {7'h00, protect_flag,
                             window_compare_result[0], 2'h0,
                             window_compare_result[1],
                             synced_compare_result[0], 2'h0,
                             synced_compare_result[1]};

  // read data mux, unmapped offsets read zero
  wire [15:0] next_rdata = sel_status ? status_word :
                           sel_config ? config_q : 16'h0000;

  // config register; bit 14 is a don't-care held at zero
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      config_q <= `CONFIG_RESET;
    end else if (config_write) begin
      config_q <= reg_wdata & `CFG_WMASK;
    end
  end

  // read data register, loads only on a read strobe
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      reg_rdata <= `STATUS_RESET;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // shutdown flag: a new set in the read cycle survives the clear
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      protect_flag <= 1'b0;
    end else if (protect_active) begin
      protect_flag <= 1'b1;
    end else if (status_read) begin
      protect_flag <= 1'b0;
    end
  end

  // window hold per channel; a high result beats a clear
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_win
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          window_compare_result[ch] <= 1'b0;
        end else if (!window_latch_enable) begin
          // transparent mode simply follows the comparator
          window_compare_result[ch] <= window_sync[ch];
        end else if (window_sync[ch]) begin
          window_compare_result[ch] <= 1'b1;
        end else if (compare_hold_clear[ch]) begin
          window_compare_result[ch] <= 1'b0;
        end
      end
    end
  endgenerate

  // pin edge history
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pin_prev <= 1'b1;
    end else begin
      pin_prev <= pin_level;
    end
  end

  // pin output stage, driven only in output mode
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      gpio_out <= 1'b0;
      gpio_oe <= 1'b0;
    end else begin
      gpio_out <= next_gpio_out;
      gpio_oe <= pin_output_enable;
    end
  end

  // global actions; high level alone triggers nothing
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      fault_dump_start <= 1'b0;
      protect_start <= 1'b0;
      clear_function_n <= 1'b1;
    end else begin
      fault_dump_start <= fn_fault && pin_fall;
      protect_start <= fn_prot && pin_fall;
      clear_function_n <= !(fn_clear && pin_low);
    end
  end

  // reset request held from falling to rising edge
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      device_reset_req <= 1'b0;
    end else if (!fn_reset) begin
      device_reset_req <= 1'b0;
    end else if (pin_fall) begin
      device_reset_req <= 1'b1;
    end else if (pin_rise) begin
      device_reset_req <= 1'b0;
    end
  end

  // nonvolatile write protection, open after a fall
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      nonvolatile_write_allow <= 1'b0;
    end else if (fn_nvp && pin_fall) begin
      nonvolatile_write_allow <= 1'b1;
    end else if (fn_nvp && pin_rise) begin
      nonvolatile_write_allow <= 1'b0;
    end
  end

  // register lock; an unlock write also opens the map
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      register_lock <= 1'b0;
    end else if (fn_lock && pin_rise) begin
      register_lock <= 1'b1;
    end else if ((fn_lock && pin_fall) || unlock_write) begin
      register_lock <= 1'b0;
    end
  end

  // per-channel edge actions, masked by channel enables
  generate
    for (ch = 0; ch < 2; ch++) begin : g_act
      wire go_fall = chan_en[ch] && pin_fall;
      wire go_rise = chan_en[ch] && pin_rise;
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          current_output_down[ch] <= 1'b0;
          current_output_up[ch] <= 1'b0;
          voltage_output_down[ch] <= 1'b0;
          voltage_output_up[ch] <= 1'b0;
          load_update[ch] <= 1'b0;
          wave_stop[ch] <= 1'b0;
          wave_start[ch] <= 1'b0;
          margin_low[ch] <= 1'b0;
          margin_high[ch] <= 1'b0;
        end else begin
          current_output_down[ch] <= fn_cur && go_fall;
          current_output_up[ch] <= fn_cur && go_rise;
          voltage_output_down[ch] <= fn_volt && go_fall;
          voltage_output_up[ch] <= fn_volt && go_rise;
          load_update[ch] <= fn_load && go_fall;
          wave_stop[ch] <= fn_wave && go_fall;
          wave_start[ch] <= fn_wave && go_rise;
          margin_low[ch] <= fn_margin && go_fall;
          margin_high[ch] <= fn_margin && go_rise;
        end
      end
    end
  endgenerate

endmodule

// ### bench/gpio_func_chk_assertions.sv
// port-level checks for the pin function and status block
`timescale 1ns/10ps
`include "gpio_func_defines.svh"
module gpio_func_chk
  import gpio_func_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  input reg_word_t reg_rdata,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  input wire logic protect_active,
  input wire logic nonvolatile_busy,
  input wire logic register_lock,
  input wire logic fault_dump_start,
  input wire logic protect_start,
  input wire logic clear_function_n,
  input wire logic [1:0] wave_stop
);
  // shadow of the config word, only writes the lock lets through
  logic [15:0] cfg_q;
  wire cfg_wr = reg_wr && reg_addr == `CONFIG_ADDR && !register_lock;
  wire st_rd = reg_rd && reg_addr == `STATUS_ADDR;
  // shadow follows accepted writes so checks see the same code and mask
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cfg_q <= 16'h0000;
    end else if (cfg_wr) begin
      cfg_q <= reg_wdata;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  flag_read_clear_a: assert property ((st_rd && !protect_active) ##1
    (!protect_active) [*2] ##0 st_rd |=> !reg_rdata[`ST_PROTECT_BIT])
    else $error("shutdown flag survived a read");
  // config lands one edge after the write, the registered enable one edge later
  oe_write_a: assert property (cfg_wr |-> ##2 gpio_oe == $past(reg_wdata[13], 2))
    else $error("pin drive enable does not follow config");
  out_select_a: assert property (cfg_q[13] && cfg_q[12:9] == `OSEL_NV_BUSY
    |=> gpio_out == $past(nonvolatile_busy))
    else $error("pin does not mirror busy status");
  mask_gate_a: assert property (wave_stop != 2'b00 |->
    (!wave_stop[0] || cfg_q[8]) && (!wave_stop[1] || cfg_q[5]))
    else $error("channel action on unselected channel");
  protect_code_a: assert property (protect_start |-> cfg_q[4:1] == `IFN_PROTECT)
    else $error("shutdown start under wrong code");
  dump_code_a: assert property (fault_dump_start |-> cfg_q[4:1] == `IFN_FAULT_DUMP)
    else $error("fault dump under wrong code");
  clear_code_a: assert property (!clear_function_n |-> cfg_q[4:1] == `IFN_CLEAR)
    else $error("clear asserted under wrong code");
  input_gate_a: assert property ((fault_dump_start || protect_start ||
    wave_stop != 2'b00 || !clear_function_n) |-> cfg_q[0])
    else $error("pin action while input mode off");
  single_pulse_a: assert property ((fault_dump_start || protect_start)
    |=> !(fault_dump_start || protect_start))
    else $error("edge action longer than one cycle");
  cover property (fault_dump_start);
  cover property (!clear_function_n);
  cover property (st_rd ##2 st_rd);
endmodule
bind gpio_function_and_comparator_and_shutdown_status gpio_func_chk chk_i (.*);

// ### bench/gpio_pin_partner.sv
// far-side logic on the general-purpose pin
`timescale 1ns/10ps
module gpio_pin_partner (
  input wire logic gpio_oe,
  input wire logic gpio_out,
  input wire logic drive_low,
  output logic pin_level
);
  // device drive wins; otherwise our open-drain pull, else the pull-up
  assign pin_level = gpio_oe ? gpio_out : !drive_low;
endmodule

// ### bench/gpio_function_and_comparator_and_shutdown_status_tb.sv
// self-checking bench for the pin function and status block
`timescale 1ns/10ps
`include "gpio_func_defines.svh"
module gpio_function_and_comparator_and_shutdown_status_tb
  import gpio_func_pkg::*;
;
  logic clk_sys, reset_n, reg_wr, reg_rd, gpio_in, gpio_out, gpio_oe, drive_low;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  reg_word_t reg_rdata;
  logic [1:0] compare_raw, window_raw, compare_hold_clear, channel_busy;
  logic window_latch_enable, protect_active, nonvolatile_busy, unlock_write;
  logic fault_dump_start, protect_start, clear_function_n, device_reset_req;
  logic nonvolatile_write_allow, register_lock;
  logic [1:0] current_output_down, current_output_up, voltage_output_down;
  logic [1:0] voltage_output_up, load_update, wave_stop, wave_start, margin_low, margin_high;
  logic [19:0] seen;
  // restart the record at the next edge; keeps one process driving it
  logic seen_clr;
  logic [3:0] osel [5] = '{`OSEL_NV_BUSY, `OSEL_CH1_BUSY, `OSEL_CH0_BUSY, `OSEL_WIN_CH1,
    `OSEL_WIN_CH0};
  logic [4:0] oexp = 5'h0d; // pin level per select entry, sources not inverted
  int error_cnt = 0;
  int n_compared = 0;
  // all edge actions side by side, channel pairs kept [1:0]
  wire [19:0] ev = {fault_dump_start, protect_start, current_output_down, current_output_up,
    voltage_output_down, voltage_output_up, load_update, wave_stop, wave_start, margin_low,
    margin_high};
  wire [3:0] lv = {clear_function_n, device_reset_req, nonvolatile_write_allow, register_lock};

  gpio_function_and_comparator_and_shutdown_status dut (.*);
  gpio_pin_partner pin_i (.gpio_oe(gpio_oe), .gpio_out(gpio_out), .drive_low(drive_low),
    .pin_level(gpio_in));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // sticky record of every action seen since the last clear
  always @(posedge clk_sys) seen <= seen_clr ? ev : (seen | ev);

  task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // every stimulus change lands 1 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    chk(reg_rdata, exp, "read data");
    tick(1);
  endtask
  // one low pulse on the pin; short pulses are glitches and expect nothing
  task automatic pin_case(input logic [15:0] cfg, input int len, input logic [19:0] ef,
      input logic [19:0] er, input logic [3:0] el, input logic [3:0] eh);
    wr(`CONFIG_ADDR, cfg);
    tick(4);
    seen_clr = 1'b1;
    drive_low = 1'b1;
    tick(1);
    seen_clr = 1'b0;
    tick(len - 1);
    if (len > 10) begin
      chk(seen, ef, "fall actions");
      chk(lv, el, "levels with pin low");
      seen_clr = 1'b1;
    end
    drive_low = 1'b0;
    tick(1);
    seen_clr = 1'b0;
    tick(23);
    chk(seen, er, "rise actions");
    chk(lv, eh, "levels with pin high");
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic results;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    compare_raw = 2'b00;
    window_raw = 2'b00;
    compare_hold_clear = 2'b00;
    channel_busy = 2'b00;
    window_latch_enable = 1'b0;
    protect_active = 1'b0;
    nonvolatile_busy = 1'b0;
    unlock_write = 1'b0;
    drive_low = 1'b0;
    seen_clr = 1'b1;
    tick(16);
    reset_n = 1'b1;
    tick(3);
    // reset values, unmapped place, spare config bit
    rd(`STATUS_ADDR, `STATUS_RESET);
    rd(`CONFIG_ADDR, `CONFIG_RESET);
    rd(8'h25, 16'h0000);
    wr(`CONFIG_ADDR, 16'hffff);
    rd(`CONFIG_ADDR, `CFG_WMASK);
    chk(gpio_oe, 1'b1, "drive enable on");
    wr(`CONFIG_ADDR, 16'h0000);
    chk(gpio_oe, 1'b0, "drive enable off");
    done("registers");
    // input functions, one pin pulse per config setting
    pin_case(16'h0005, 24, 20'h8_0000, 20'h0, 4'h8, 4'h8);
    pin_case(16'h0004, 24, 20'h0, 20'h0, 4'h8, 4'h8);
    pin_case(16'h8005, 6, 20'h0, 20'h0, 4'h8, 4'h8);
    pin_case(16'h8005, 24, 20'h8_0000, 20'h0, 4'h8, 4'h8);
    pin_case(16'h0107, 24, 20'h1_0000, 20'h0_4000, 4'h8, 4'h8);
    pin_case(16'h0029, 24, 20'h0_2000, 20'h0_0800, 4'h8, 4'h8);
    pin_case(16'h000b, 24, 20'h4_0000, 20'h0, 4'h8, 4'h8);
    pin_case(16'h012d, 24, 20'h0, 20'h0, 4'h8, 4'h8);
    pin_case(16'h000f, 24, 20'h0, 20'h0, 4'h0, 4'h8);
    pin_case(16'h0131, 24, 20'h0_0300, 20'h0, 4'h8, 4'h8);
    pin_case(16'h0133, 24, 20'h0_00c0, 20'h0_0030, 4'h8, 4'h8);
    pin_case(16'h0135, 24, 20'h0_000c, 20'h0_0003, 4'h8, 4'h8);
    pin_case(16'h0017, 24, 20'h0, 20'h0, 4'hc, 4'h8);
    pin_case(16'h0019, 24, 20'h0, 20'h0, 4'ha, 4'h8);
    pin_case(16'h001b, 24, 20'h0, 20'h0, 4'h8, 4'h9);
    // locked map refuses the write until an unlock arrives
    wr(`CONFIG_ADDR, 16'h0000);
    rd(`CONFIG_ADDR, 16'h001b);
    unlock_write = 1'b1;
    tick(1);
    unlock_write = 1'b0;
    tick(2);
    chk(register_lock, 1'b0, "lock after unlock");
    wr(`CONFIG_ADDR, 16'h0000);
    rd(`STATUS_ADDR, 16'h0000);
    done("pin inputs");
    // status bits and pin output select, sources then inverted
    for (int p = 0; p < 2; p++) begin
      nonvolatile_busy = ~p[0];
      channel_busy = p[0] ? 2'b10 : 2'b01;
      window_raw = p[0] ? 2'b01 : 2'b10;
      compare_raw = p[0] ? 2'b10 : 2'b01;
      tick(6);
      rd(`STATUS_ADDR, p[0] ? 16'h0081 : 16'h0018);
      for (int k = 0; k < 5; k++) begin
        wr(`CONFIG_ADDR, {3'h1, osel[k], 9'h000});
        tick(3);
        chk(gpio_in, oexp[k] ^ p[0], "pin drive level");
      end
    end
    wr(`CONFIG_ADDR, 16'h0000);
    chk(gpio_in, 1'b1, "released pin");
    done("status and output");
    // shutdown flag is cleared by its own read
    nonvolatile_busy = 1'b0;
    channel_busy = 2'b00;
    window_raw = 2'b00;
    compare_raw = 2'b00;
    tick(6);
    rd(`STATUS_ADDR, 16'h0000);
    protect_active = 1'b1;
    tick(1);
    protect_active = 1'b0;
    tick(1);
    rd(`STATUS_ADDR, 16'h0100);
    rd(`STATUS_ADDR, 16'h0000);
    // held window result survives the source and goes on clear
    window_latch_enable = 1'b1;
    window_raw = 2'b01;
    tick(6);
    window_raw = 2'b00;
    tick(6);
    rd(`STATUS_ADDR, 16'h0080);
    compare_hold_clear = 2'b01;
    tick(1);
    compare_hold_clear = 2'b00;
    tick(2);
    rd(`STATUS_ADDR, 16'h0000);
    done("flags");
    results();
  end
endmodule
